// ### logic/volume_ctrl_pkg.sv
package volume_ctrl_pkg;

	localparam int          NUM_CH          = 8;
	localparam int          NUM_MASTER      = 3;
	localparam int          LVL_W           = 9;
	localparam int          CLK_HZ          = 25_000_000;
	localparam int          MS_PER_S        = 1000;
	localparam int          MS_CYCLES       = CLK_HZ / MS_PER_S;

	////////////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [7:0]  REG_VOL_FIRST   = 8'h01;
	localparam logic [7:0]  REG_VOL_LAST    = 8'h08;
	localparam logic [7:0]  REG_QUARTER     = 8'h09;
	localparam logic [7:0]  REG_CH_POWER    = 8'h0D;
	localparam logic [7:0]  REG_DEV_CFG     = 8'h0E;
	localparam logic [7:0]  REG_ZC_CFG      = 8'h0F;
	localparam logic [7:0]  REG_MASTER_BASE = 8'h10;
	localparam logic [7:0]  MASTER_STRIDE   = 8'h03;
	localparam logic [7:0]  MASTER_VOL_OFS  = 8'h01;
	localparam logic [7:0]  MASTER_CTL_OFS  = 8'h02;
	localparam logic [7:0]  REG_AMP_STATUS  = 8'h19;
	localparam logic [7:0]  REG_MUTE_STATUS = 8'h1A;
	localparam logic [7:0]  REG_GROUP       = 8'h1B;

	////////////////////////////////////////////////////////////////////////////////
	// fields and reset values
	localparam int          GLOBAL_PDN_BIT  = 0;
	localparam int          ZC_ENABLE_BIT   = 0;
	localparam int          ZC_TMO_LSB      = 1;
	localparam int          ZC_TMO_MSB      = 3;
	localparam int          ZC_DISCARD_BIT  = 4;
	localparam int          QUARTER_BIT     = 0;
	localparam int          GROUP_EN_BIT    = 7;
	localparam logic [7:0]  CH_POWER_RST    = 8'h00;
	localparam logic [7:0]  DEV_CFG_RST     = 8'h01;
	localparam logic [7:0]  ZC_CFG_RST      = 8'h00;
	localparam logic [7:0]  VOL_RST         = 8'hC0;
	localparam logic [7:0]  MASK_RST        = 8'hFF;
	localparam logic [7:0]  GROUP_RST       = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// volume coding: code = half-dB steps above -96 dB, level = quarter-dB steps
	localparam logic signed [11:0] LVL_OFFSET = 12'h180;
	localparam logic signed [11:0] LVL_MAX    = 12'h1D8;
	localparam logic signed [11:0] LVL_MIN    = 12'h000;

	////////////////////////////////////////////////////////////////////////////////
	// serial frame: chip byte, map byte, data byte
	localparam logic [4:0]  BIT_CHIP_DONE   = 5'h08;
	localparam logic [4:0]  BIT_MAP_DONE    = 5'h10;
	localparam logic [4:0]  BIT_DATA_DONE   = 5'h18;
	localparam logic [1:0]  STRAP_CAPTURE   = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// timing in milliseconds
	localparam logic [7:0]  AMP_SEQ_MS      = 8'h0A;
	localparam logic [7:0]  ZC_TIMEOUT_MS [8] = '{8'h05, 8'h0A, 8'h0F, 8'h14, 8'h19, 8'h1E, 8'h28, 8'h32};

	typedef enum logic [2:0] {
		CH_OFF       = 3'b000,
		CH_RAMP_UP   = 3'b001,
		CH_UNMUTE    = 3'b010,
		CH_ON        = 3'b011,
		CH_MUTE      = 3'b100,
		CH_RAMP_DOWN = 3'b101
	} chan_state_e;

endpackage

// ### logic/channel_seq.sv
`timescale 1ns/1ns
module channel_seq
	import volume_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// timing and zero crossing
	input  wire logic              msTick,
	input  wire logic              zcEdge,
	// configuration
	input  wire logic              immediate,
	input  wire logic [7:0]        tmoMs,
	input  wire logic              discard,
	input  wire logic              powerDown,
	input  wire logic [LVL_W-1:0]  target,
	// analog controls
	output logic      [LVL_W-1:0]  level_ff,
	output logic                   mute_ff,
	output logic                   ampOn_ff
);

	chan_state_e         state_ff, nxt_state;
	logic [LVL_W-1:0]    pend_ff, nxt_pend, lastTgt_ff, nxt_level;
	logic                pendValid_ff, nxt_pendValid, nxt_mute, nxt_ampOn;
	logic [7:0]          cnt_ff, nxt_cnt;
	logic                clrCnt;

	wire  cmd      = (target != lastTgt_ff);
	wire  timedOut = (cnt_ff >= tmoMs);
	wire  applyNow = immediate | zcEdge | timedOut;
	wire  seqDone  = (cnt_ff >= AMP_SEQ_MS);

	always_comb begin
		nxt_state     = state_ff;
		nxt_pend      = pend_ff;
		nxt_pendValid = pendValid_ff;
		nxt_level     = level_ff;
		nxt_mute      = mute_ff;
		nxt_ampOn     = ampOn_ff;
		clrCnt        = 1'b0;
		case (state_ff)
			CH_OFF: begin
				nxt_mute  = 1'b1;
				nxt_ampOn = 1'b0;
				if (!powerDown) begin
					nxt_state = CH_RAMP_UP;
					nxt_ampOn = 1'b1;
					clrCnt    = 1'b1;
				end
			end
			CH_RAMP_UP: begin
				// held at mute until the amplifier has settled
				if (powerDown) begin
					nxt_state = CH_RAMP_DOWN;
					nxt_ampOn = 1'b0;
					clrCnt    = 1'b1;
				end else if (seqDone) begin
					nxt_state = CH_UNMUTE;
					clrCnt    = 1'b1;
				end
			end
			CH_UNMUTE: begin
				if (powerDown) begin
					nxt_state = CH_RAMP_DOWN;
					nxt_ampOn = 1'b0;
					clrCnt    = 1'b1;
				end else if (applyNow) begin
					nxt_level     = target;
					nxt_mute      = 1'b0;
					nxt_pendValid = 1'b0;
					nxt_state     = CH_ON;
				end
			end
			CH_ON: begin
				if (powerDown) begin
					nxt_state = CH_MUTE;
					clrCnt    = 1'b1;
				end else if (cmd) begin
					if (pendValid_ff && !discard) begin
						nxt_level = pend_ff;
					end
					if (immediate) begin
						nxt_level     = target;
						nxt_pendValid = 1'b0;
					end else begin
						nxt_pend      = target;
						nxt_pendValid = 1'b1;
						clrCnt        = 1'b1;
					end
				end else if (pendValid_ff && applyNow) begin
					nxt_level     = pend_ff;
					nxt_pendValid = 1'b0;
				end
			end
			CH_MUTE: begin
				if (!powerDown) begin
					nxt_state = CH_ON;
				end else if (applyNow) begin
					nxt_mute      = 1'b1;
					nxt_ampOn     = 1'b0;
					nxt_pendValid = 1'b0;
					nxt_state     = CH_RAMP_DOWN;
					clrCnt        = 1'b1;
				end
			end
			CH_RAMP_DOWN: begin
				// the power-down sequence always runs to its end
				if (seqDone) begin
					nxt_state = CH_OFF;
				end
			end
			default: begin
				nxt_state = CH_OFF;
				nxt_mute  = 1'b1;
				nxt_ampOn = 1'b0;
			end
		endcase
	end

	// millisecond counter saturates so a stale timeout stays expired
	always_comb begin
		if (clrCnt) begin
			nxt_cnt = 8'h00;
		end else if (msTick && cnt_ff != 8'hFF) begin
			nxt_cnt = cnt_ff + 8'h01;
		end else begin
			nxt_cnt = cnt_ff;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff     <= CH_OFF;
			pend_ff      <= '0;
			pendValid_ff <= 1'b0;
			level_ff     <= '0;
			lastTgt_ff   <= '0;
			mute_ff      <= 1'b1;
			ampOn_ff     <= 1'b0;
			cnt_ff       <= 8'h00;
		end else begin
			state_ff     <= nxt_state;
			pend_ff      <= nxt_pend;
			pendValid_ff <= nxt_pendValid;
			level_ff     <= nxt_level;
			lastTgt_ff   <= target;
			mute_ff      <= nxt_mute;
			ampOn_ff     <= nxt_ampOn;
			cnt_ff       <= nxt_cnt;
		end
	end

endmodule

// ### logic/channel_power_and_volume_update.sv
`timescale 1ns/1ns
// Overview of operation
// - each volume change applies at once or at next zero crossing, per configuration.
// - eight selectable timeouts 5-50 ms force the pending change when expired.
// - second command either applies the earlier one at once or discards it.
// - while reset is low everything is powered down and traffic ignored.
// - after reset port works but amplifiers stay off while global bit set.
// - channel powers up only when global and its own bit are clear.
// - reset clears all channel power-down bits and sets the global bit.
// - volume is forced to mute during a channel's amplifier power-up.
// - after power-up the volume goes to the register setting automatically.
// - channel powers down when its own bit or the global bit is set.
// - channel is muted in the same cycle that its amplifier power-down begins.
// - power-related mute and unmute obey the zero-crossing and timeout settings.
// - gain spans 118 dB in quarter-dB steps, -96 dB to +22 dB.
// - up to 128 devices share the bus, each with its own address.
// - device answers its own address and an enabled group address.
// - effective volume is individual plus masked masters, clamped to range.
module channel_power_and_volume_update
	import volume_ctrl_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	// serial control port
	input  wire logic                     csPin_n,
	input  wire logic                     cclkPin,
	input  wire logic                     cdinPin,
	output logic                          cdout_ff,
	output logic                          cdoutEn_ff,
	// address straps
	input  wire logic [6:0]               addrPins,
	// zero-crossing comparators
	input  wire logic [NUM_CH-1:0]        zcPins,
	// analog channel controls
	output logic      [NUM_CH*LVL_W-1:0]  chLevel,
	output logic      [NUM_CH-1:0]        chMute,
	output logic      [NUM_CH-1:0]        chAmpOn
);

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [2:0]         csSync_ff, clkSync_ff;
	logic [1:0]         dinSync_ff;
	logic [6:0]         addrSync1_ff, addrSync2_ff;
	logic [NUM_CH-1:0]  zcSync1_ff, zcSync2_ff, zcSync3_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			csSync_ff    <= 3'h7;
			clkSync_ff   <= 3'h0;
			dinSync_ff   <= 2'h0;
			addrSync1_ff <= 7'h00;
			addrSync2_ff <= 7'h00;
			zcSync1_ff   <= '0;
			zcSync2_ff   <= '0;
			zcSync3_ff   <= '0;
		end else begin
			csSync_ff    <= {csSync_ff[1:0], csPin_n};
			clkSync_ff   <= {clkSync_ff[1:0], cclkPin};
			dinSync_ff   <= {dinSync_ff[0], cdinPin};
			addrSync1_ff <= addrPins;
			addrSync2_ff <= addrSync1_ff;
			zcSync1_ff   <= zcPins;
			zcSync2_ff   <= zcSync1_ff;
			zcSync3_ff   <= zcSync2_ff;
		end
	end

	wire               csLow   = ~csSync_ff[1];
	wire               sclkRise = clkSync_ff[1] & ~clkSync_ff[2];
	wire               sclkFall = ~clkSync_ff[1] & clkSync_ff[2];
	wire               dinBit  = dinSync_ff[1];
	// either comparator edge marks a crossing
	wire [NUM_CH-1:0]  zcEdge  = zcSync2_ff ^ zcSync3_ff;

	////////////////////////////////////////////////////////////////////////////////
	// strap capture, after reset release
	logic [1:0]  strapCnt_ff;
	logic [6:0]  devAddr_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strapCnt_ff <= 2'h0;
			devAddr_ff  <= 7'h00;
		end else if (strapCnt_ff != 2'h3) begin
			strapCnt_ff <= strapCnt_ff + 2'h1;
			if (strapCnt_ff == STRAP_CAPTURE) begin
				devAddr_ff <= addrSync2_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// millisecond tick; timeouts may end up to one tick early
	logic [31:0]  tickCnt_ff;
	logic         msTick_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_ff <= 32'h0;
			msTick_ff  <= 1'b0;
		end else begin
			msTick_ff  <= (tickCnt_ff == 32'(MS_TICK_CYCLES - 1));
			tickCnt_ff <= (tickCnt_ff == 32'(MS_TICK_CYCLES - 1)) ? 32'h0 : tickCnt_ff + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// serial frame receiver
	logic [4:0]  bitCnt_ff;
	logic [7:0]  shift_ff, mapAddr_ff, outShift_ff;
	logic        hit_ff, readOp_ff;

	logic [7:0]  volReg_ff [NUM_CH];
	logic [7:0]  quarter_ff, chPower_ff, devCfg_ff, zcCfg_ff, group_ff;
	logic [7:0]  mMask_ff [NUM_MASTER];
	logic [7:0]  mVol_ff [NUM_MASTER];
	logic [7:0]  mCtl_ff [NUM_MASTER];

	wire [7:0]  shiftNext  = {shift_ff[6:0], dinBit};
	wire [4:0]  bitNext    = bitCnt_ff + 5'h1;
	wire        groupHit   = group_ff[GROUP_EN_BIT] & (shiftNext[7:1] == group_ff[6:0]);
	wire        chipHit    = (shiftNext[7:1] == devAddr_ff) | groupHit;
	wire        byteChip   = csLow & sclkRise & (bitNext == BIT_CHIP_DONE);
	wire        byteMap    = csLow & sclkRise & (bitNext == BIT_MAP_DONE);
	wire        byteData   = csLow & sclkRise & (bitNext == BIT_DATA_DONE);
	wire        wrStrobe   = byteData & hit_ff & ~readOp_ff;
	wire        rdWindow   = csLow & hit_ff & readOp_ff & (bitCnt_ff >= BIT_MAP_DONE) & (bitCnt_ff < BIT_DATA_DONE);
	wire [7:0]  wrData     = shiftNext;

	logic [7:0] rdData;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bitCnt_ff   <= 5'h00;
			shift_ff    <= 8'h00;
			mapAddr_ff  <= 8'h00;
			hit_ff      <= 1'b0;
			readOp_ff   <= 1'b0;
			outShift_ff <= 8'h00;
			cdout_ff    <= 1'b0;
			cdoutEn_ff  <= 1'b0;
		end else if (!csLow) begin
			bitCnt_ff  <= 5'h00;
			hit_ff     <= 1'b0;
			cdoutEn_ff <= 1'b0;
		end else begin
			if (sclkRise && bitCnt_ff != 5'h1F) begin
				bitCnt_ff <= bitNext;
				shift_ff  <= shiftNext;
			end
			if (byteChip) begin
				hit_ff    <= chipHit;
				readOp_ff <= shiftNext[0];
			end
			if (byteMap) begin
				mapAddr_ff  <= shiftNext;
				outShift_ff <= rdData;
			end
			// read data change on falling edges, first bit after the map byte
			if (sclkFall && rdWindow) begin
				cdout_ff    <= outShift_ff[7];
				outShift_ff <= {outShift_ff[6:0], 1'b0};
			end
			cdoutEn_ff <= rdWindow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file
	wire [7:0]  wAddr   = mapAddr_ff;
	wire        inVol   = (wAddr >= REG_VOL_FIRST) && (wAddr <= REG_VOL_LAST);
	wire [2:0]  volIdx  = 3'(wAddr - REG_VOL_FIRST);
	wire [7:0]  mOfs    = wAddr - REG_MASTER_BASE;
	wire        inMast  = (wAddr >= REG_MASTER_BASE) && (mOfs < 8'(NUM_MASTER * MASTER_STRIDE));
	wire [1:0]  mIdx    = 2'(mOfs / MASTER_STRIDE);
	wire [7:0]  mSub    = mOfs % MASTER_STRIDE;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				volReg_ff[i] <= VOL_RST;
			end
			for (int m = 0; m < NUM_MASTER; m++) begin
				mMask_ff[m] <= MASK_RST;
				mVol_ff[m]  <= VOL_RST;
				mCtl_ff[m]  <= 8'h00;
			end
			quarter_ff <= 8'h00;
			chPower_ff <= CH_POWER_RST;
			devCfg_ff  <= DEV_CFG_RST;
			zcCfg_ff   <= ZC_CFG_RST;
			group_ff   <= GROUP_RST;
		end else if (wrStrobe) begin
			if (inVol) volReg_ff[volIdx] <= wrData;
			if (inMast && mSub == 8'h00) mMask_ff[mIdx] <= wrData;
			if (inMast && mSub == MASTER_VOL_OFS) mVol_ff[mIdx] <= wrData;
			if (inMast && mSub == MASTER_CTL_OFS) mCtl_ff[mIdx] <= wrData;
			if (wAddr == REG_QUARTER) quarter_ff <= wrData;
			if (wAddr == REG_CH_POWER) chPower_ff <= wrData;
			if (wAddr == REG_DEV_CFG) devCfg_ff <= wrData;
			if (wAddr == REG_ZC_CFG) zcCfg_ff <= wrData;
			if (wAddr == REG_GROUP) group_ff <= wrData;
		end
	end

	// read mux uses the map byte just received
	wire [7:0]  rAddr  = shiftNext;
	wire        rInVol = (rAddr >= REG_VOL_FIRST) && (rAddr <= REG_VOL_LAST);
	wire [2:0]  rVIdx  = 3'(rAddr - REG_VOL_FIRST);
	wire [7:0]  rMOfs  = rAddr - REG_MASTER_BASE;
	wire        rInM   = (rAddr >= REG_MASTER_BASE) && (rMOfs < 8'(NUM_MASTER * MASTER_STRIDE));
	wire [1:0]  rMIdx  = 2'(rMOfs / MASTER_STRIDE);
	wire [7:0]  rMSub  = rMOfs % MASTER_STRIDE;

	always_comb begin
		rdData = 8'h00;
		if (rInVol) rdData = volReg_ff[rVIdx];
		if (rInM && rMSub == 8'h00) rdData = mMask_ff[rMIdx];
		if (rInM && rMSub == MASTER_VOL_OFS) rdData = mVol_ff[rMIdx];
		if (rInM && rMSub == MASTER_CTL_OFS) rdData = mCtl_ff[rMIdx];
		if (rAddr == REG_QUARTER) rdData = quarter_ff;
		if (rAddr == REG_CH_POWER) rdData = chPower_ff;
		if (rAddr == REG_DEV_CFG) rdData = devCfg_ff;
		if (rAddr == REG_ZC_CFG) rdData = zcCfg_ff;
		if (rAddr == REG_GROUP) rdData = group_ff;
		if (rAddr == REG_AMP_STATUS) rdData = chAmpOn;
		if (rAddr == REG_MUTE_STATUS) rdData = chMute;
	end

	////////////////////////////////////////////////////////////////////////////////
	// effective level and per-channel sequencers
	wire        zcImmediate = ~zcCfg_ff[ZC_ENABLE_BIT];
	wire        zcDiscard   = zcCfg_ff[ZC_DISCARD_BIT];
	wire [7:0]  tmoMs       = ZC_TIMEOUT_MS[zcCfg_ff[ZC_TMO_MSB:ZC_TMO_LSB]];
	wire        globalPdn   = devCfg_ff[GLOBAL_PDN_BIT];

	wire signed [11:0] mLvl [NUM_MASTER];
	for (genvar m = 0; m < NUM_MASTER; m++) begin : g_master
		assign mLvl[m] = $signed({3'h0, mVol_ff[m], mCtl_ff[m][QUARTER_BIT]}) - LVL_OFFSET;
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		// quarter-dB units, zero at -96 dB
		wire signed [11:0] indiv = $signed({3'h0, volReg_ff[c], quarter_ff[c]});
		wire signed [11:0] sum   = indiv
		                         + (mMask_ff[0][c] ? mLvl[0] : 12'sh000)
		                         + (mMask_ff[1][c] ? mLvl[1] : 12'sh000)
		                         + (mMask_ff[2][c] ? mLvl[2] : 12'sh000);
		wire signed [11:0] clamped = (sum > LVL_MAX) ? LVL_MAX : ((sum < LVL_MIN) ? LVL_MIN : sum);
		wire               pdn     = globalPdn | chPower_ff[c];

		channel_seq u_seq (
			.clk       (clk),
			.arst_n    (arst_n),
			.msTick    (msTick_ff),
			.zcEdge    (zcEdge[c]),
			.immediate (zcImmediate),
			.tmoMs     (tmoMs),
			.discard   (zcDiscard),
			.powerDown (pdn),
			.target    (clamped[LVL_W-1:0]),
			.level_ff  (chLevel[c*LVL_W +: LVL_W]),
			.mute_ff   (chMute[c]),
			.ampOn_ff  (chAmpOn[c])
		);
	end

endmodule

// ### bench/volume_update_checker.sv
`timescale 1ns/1ns
module volume_update_checker
	import volume_ctrl_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES
) (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     arst_n,
	// serial port
	input wire logic                     csPin_n,
	input wire logic                     cclkPin,
	input wire logic                     cdinPin,
	input wire logic                     cdout_ff,
	input wire logic                     cdoutEn_ff,
	// straps and comparators
	input wire logic [6:0]               addrPins,
	input wire logic [NUM_CH-1:0]        zcPins,
	// channel controls
	input wire logic [NUM_CH*LVL_W-1:0]  chLevel,
	input wire logic [NUM_CH-1:0]        chMute,
	input wire logic [NUM_CH-1:0]        chAmpOn
);
	logic overRange;

	always_comb begin
		overRange = 1'b0;
		for (int c = 0; c < NUM_CH; c++)
			if (chLevel[c*LVL_W +: LVL_W] > 9'h1D8)
				overRange = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_held_mute;
		chMute[0] [*8];
	endsequence
	sequence s_off_quiet;
		(chAmpOn == 8'h00) [*8];
	endsequence

	// reset itself is the cause here, so this one is never disabled
	property p_reset_quiet;
		disable iff (1'b0) !arst_n |-> chAmpOn == 8'h00 && chMute == 8'hFF && !cdoutEn_ff;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
	property p_stay_off;
		$rose(arst_n) |-> s_off_quiet;
	endproperty
	a_stay_off: assert property (p_stay_off) else $error("amp on after reset");
	property p_ramp_mute;
		$rose(chAmpOn[0]) |-> s_held_mute;
	endproperty
	a_ramp_mute: assert property (p_ramp_mute) else $error("unmuted during ramp");
	property p_fall_muted;
		((~chAmpOn & $past(chAmpOn)) & ~chMute) == 8'h00;
	endproperty
	a_fall_muted: assert property (p_fall_muted) else $error("amp off while unmuted");
	property p_off_muted;
		(chMute | chAmpOn) == 8'hFF;
	endproperty
	a_off_muted: assert property (p_off_muted) else $error("unmuted channel powered down");
	property p_level_range;
		!overRange;
	endproperty
	a_level_range: assert property (p_level_range) else $error("level above range");
	property p_level_frozen;
		!$stable(chLevel[8:0]) |-> !chMute[0];
	endproperty
	a_level_frozen: assert property (p_level_frozen) else $error("level moved while muted");
	property p_drive_release;
		$rose(csPin_n) |-> ##[0:4] !cdoutEn_ff;
	endproperty
	a_drive_release: assert property (p_drive_release) else $error("drive held after frame");
	property p_drive_needs_cs;
		cdoutEn_ff |-> $past(csPin_n, 5) == 1'b0;
	endproperty
	a_drive_needs_cs: assert property (p_drive_needs_cs) else $error("drive without select");
endmodule

bind channel_power_and_volume_update volume_update_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) chk (
	.clk(clk), .arst_n(arst_n), .csPin_n(csPin_n), .cclkPin(cclkPin), .cdinPin(cdinPin),
	.cdout_ff(cdout_ff), .cdoutEn_ff(cdoutEn_ff), .addrPins(addrPins), .zcPins(zcPins),
	.chLevel(chLevel), .chMute(chMute), .chAmpOn(chAmpOn));

// ### bench/serial_host.sv
`timescale 1ns/1ns
module serial_host (
	// clock
	input  wire logic        clk,
	// serial pins
	output logic             csPin_n,
	output logic             cclkPin,
	output logic             cdinPin,
	input  wire logic        cdout_ff,
	// read result
	output logic             rdDone,
	output logic [7:0]       rdData
);
	logic [23:0] frameBits;

	initial begin
		csPin_n = 1'b1;
		cclkPin = 1'b0;
		cdinPin = 1'b0;
		rdDone  = 1'b0;
		rdData  = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock idles low between frames; released data shows the inverse of its last bit
	task automatic xfer(input logic [6:0] dev, input logic rw, input logic [7:0] regAddr, input logic [7:0] wdat);
		frameBits = {dev, rw, regAddr, wdat};
		repeat (25) @(posedge clk);
		csPin_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			cdinPin <= frameBits[i];
			repeat (4) @(posedge clk);
			cclkPin <= 1'b1;
			if (i < 8)
				rdData[i] <= cdout_ff;
			repeat (4) @(posedge clk);
			cclkPin <= 1'b0;
		end
		csPin_n <= 1'b1;
		cdinPin <= ~frameBits[0];
		rdDone  <= rw;
		@(posedge clk);
		rdDone  <= 1'b0;
	endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import volume_ctrl_pkg::*;
;
	localparam int          TICK = 10;
	localparam logic [6:0]  DEV  = 7'h2A;
	localparam logic [6:0]  GRP  = 7'h55;

	typedef struct {
		string       what;
		logic [15:0] v;
	} note_s;

	logic                     clk, arst_n, csPin_n, cclkPin, cdinPin, cdout_ff, cdoutEn_ff;
	logic                     rdDone, probe;
	logic [NUM_CH-1:0]        zcPins, chMute, chAmpOn;
	logic [NUM_CH*LVL_W-1:0]  chLevel;
	logic [7:0]               rdData, v0, v1;
	logic [3:0]               probeSel;
	logic [15:0]              seen;
	int                       mismatches, comparisons;
	note_s                    notes[$];

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	channel_power_and_volume_update #(.MS_TICK_CYCLES(TICK)) uut (
		.clk(clk), .arst_n(arst_n), .csPin_n(csPin_n), .cclkPin(cclkPin), .cdinPin(cdinPin),
		.cdout_ff(cdout_ff), .cdoutEn_ff(cdoutEn_ff), .addrPins(DEV), .zcPins(zcPins),
		.chLevel(chLevel), .chMute(chMute), .chAmpOn(chAmpOn));
	serial_host host (.clk(clk), .csPin_n(csPin_n), .cclkPin(cclkPin), .cdinPin(cdinPin),
		.cdout_ff(cdout_ff), .rdDone(rdDone), .rdData(rdData));

	////////////////////////////////////////////////////////////////////////////////
	assign seen = (probeSel == 4'h0) ? {8'h00, chAmpOn} : (probeSel == 4'h1) ? {8'h00, chMute} :
		{7'h00, chLevel[(probeSel - 4'h2) * LVL_W +: LVL_W]};

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// results arrive in the order they were noted
	always @(posedge clk) begin
		if (rdDone || probe) begin
			if (notes.size() == 0)
				check("note queue", 16'hFFFF, 16'h0000);
			else
				check(notes[0].what, notes[0].v, rdDone ? {8'h00, rdData} : seen);
			if (notes.size() != 0)
				notes.pop_front();
		end
	end

	task automatic probeNote(input string what, input logic [3:0] sel, input logic [15:0] v);
		notes.push_back('{what, v});
		probeSel <= sel;
		probe    <= 1'b1;
		@(posedge clk);
		probe    <= 1'b0;
		@(posedge clk);
	endtask

	task automatic waitOut(input logic [3:0] sel, input logic [15:0] v, input int lim);
		int n;
		n = 0;
		probeSel <= sel;
		@(posedge clk);
		while (seen !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (seen !== v) begin
			check("wait limit", v, seen);
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] v, input string what);
		notes.push_back('{what, {8'h00, v}});
		host.xfer(DEV, 1'b1, a, 8'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(DEV, 1'b0, a, d);
	endtask

	// masters stay neutral, quarter bits clear: level is twice the code, clamped
	function automatic logic [15:0] lvl(input logic [7:0] v);
		return ({7'h00, v, 1'b0} > 16'h01D8) ? 16'h01D8 : {7'h00, v, 1'b0};
	endfunction

	task automatic toggleZc(input logic [7:0] m);
		zcPins <= zcPins ^ m;
		repeat (8) @(posedge clk);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		check("watchdog", 16'h0000, 16'h0001);
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		arst_n      = 1'b1;
		zcPins      = 8'h00;
		probe       = 1'b0;
		probeSel    = 4'h0;
		mismatches  = 0;
		comparisons = 0;
		void'($urandom(32'h64C1A4E7));
		// start high so the fall into reset is an edge that every register sees
		#1 arst_n = 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd(REG_CH_POWER, 8'h00, "ch power");
		rd(REG_DEV_CFG, 8'h01, "dev cfg");
		rd(8'h30, 8'h00, "unmapped");
		host.xfer(DEV ^ 7'h01, 1'b0, REG_DEV_CFG, 8'h00);
		rd(REG_DEV_CFG, 8'h01, "foreign write");
		wr(REG_GROUP, {1'b1, GRP});
		host.xfer(GRP, 1'b0, 8'h02, 8'h5A);
		rd(8'h02, 8'h5A, "group write");
		arst_n <= 1'b0;
		wr(REG_DEV_CFG, 8'h00);
		probeNote("amp in reset", 4'h0, 16'h0000);
		arst_n <= 1'b1;
		rd(REG_DEV_CFG, 8'h01, "write in reset");
		$display("test reset done");

		v0 = 8'($urandom_range(255, 0));
		wr(8'h01, v0);
		wr(REG_ZC_CFG, 8'h00);
		probeNote("amp held", 4'h0, 16'h0000);
		wr(REG_DEV_CFG, 8'h00);
		probeNote("amp up", 4'h0, 16'h00FF);
		repeat (8 * TICK) @(posedge clk);
		probeNote("ramp mute", 4'h1, 16'h00FF);
		waitOut(4'h1, 16'h0000, 4 * TICK);
		probeNote("level", 4'h2, lvl(v0));
		$display("test power-up done");

		wr(REG_CH_POWER, 8'h05);
		probeNote("amp ch", 4'h0, 16'h00FA);
		probeNote("mute ch", 4'h1, 16'h0005);
		rd(REG_AMP_STATUS, 8'hFA, "amp status");
		wr(REG_CH_POWER, 8'h00);
		waitOut(4'h1, 16'h0000, 20 * TICK);
		probeNote("level ch2", 4'h4, lvl(VOL_RST));
		wr(REG_DEV_CFG, 8'h01);
		probeNote("amp all", 4'h0, 16'h0000);
		wr(REG_DEV_CFG, 8'h00);
		waitOut(4'h1, 16'h0000, 20 * TICK);
		$display("test channel power done");

		for (int s = 0; s < 8; s++) begin
			wr(REG_ZC_CFG, {4'h0, 3'(s), 1'b1});
			v1 = 8'($urandom_range(235, 0));
			if (v1 == v0)
				v1 = v1 + 8'h01;
			wr(8'h01, v1);
			repeat (int'(ZC_TIMEOUT_MS[s]) * TICK - TICK - 6) @(posedge clk);
			probeNote("zc hold", 4'h2, lvl(v0));
			repeat (TICK + 8) @(posedge clk);
			probeNote("zc timeout", 4'h2, lvl(v1));
			v0 = v1;
		end
		wr(REG_ZC_CFG, 8'h01);
		wr(REG_CH_POWER, 8'h01);
		probeNote("mute waits", 4'h1, 16'h0000);
		waitOut(4'h1, 16'h0001, 8 * TICK);
		probeNote("amp down", 4'h0, 16'h00FE);
		wr(REG_CH_POWER, 8'h00);
		waitOut(4'h1, 16'h0000, 20 * TICK);
		$display("test timeout done");

		wr(REG_ZC_CFG, 8'h0F);
		wr(8'h01, 8'h10);
		wr(8'h02, 8'h20);
		toggleZc(8'h02);
		probeNote("zc ch1", 4'h3, lvl(8'h20));
		probeNote("zc ch0", 4'h2, lvl(v0));
		wr(8'h01, 8'h30);
		probeNote("keep earlier", 4'h2, lvl(8'h10));
		toggleZc(8'h01);
		probeNote("zc ch0 new", 4'h2, lvl(8'h30));
		wr(REG_ZC_CFG, 8'h1F);
		wr(8'h01, 8'h40);
		wr(8'h01, 8'h50);
		probeNote("drop earlier", 4'h2, lvl(8'h30));
		toggleZc(8'h01);
		probeNote("newest", 4'h2, lvl(8'h50));
		$display("test zero crossing done");

		wr(REG_ZC_CFG, 8'h00);
		wr(REG_QUARTER, 8'h01);
		wr(REG_MASTER_BASE, 8'h01);
		wr(REG_MASTER_BASE + MASTER_VOL_OFS, 8'hD0);
		// master 0 adds 8 dB (32 quarter steps) to channel 0 only, plus channel 0's quarter bit
		probeNote("master ch0", 4'h2, lvl(8'h50) + 16'h0021);
		probeNote("masked ch1", 4'h3, lvl(8'h20));
		wr(8'h01, 8'hE0);
		probeNote("clamp ch0", 4'h2, 16'h01D8);
		$display("test master volume done");
		report_and_stop();
	end
endmodule
